// ---- dmf_consts.vh ----
`ifndef DMF_CONSTS_VH
`define DMF_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DMF_OFS_FAIL_MASK 8'h00
`define DMF_OFS_METER_TYPE 8'h04
`define DMF_OFS_RETRY_LIMIT 8'h08
`define DMF_OFS_COMM_INTERVAL 8'h0C
`define DMF_OFS_MEAS_INTERVAL 8'h10
`define DMF_OFS_LINK_SELECT 8'h14
`define DMF_OFS_RUN_GATING 8'h18
`define DMF_OFS_MON_SEL 8'h1C
`define DMF_OFS_MON_SEL_E 8'h20
`define DMF_OFS_STATUS 8'h24
`define DMF_OFS_RANGE_LOW 8'h28
`define DMF_OFS_RANGE_HIGH 8'h2C

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DMF_MASK_BIT 4
`define DMF_LINK_ACTIVE 4'h1
`define DMF_MON_SHOW_CODE 8'h36
`define DMF_RST_FAIL_MASK 8'h00
`define DMF_RST_METER_TYPE 3'h0
`define DMF_RST_RETRY_LIMIT 8'h03
`define DMF_RST_INTERVAL 32'h000F4240
`define DMF_RST_LINK_SELECT 4'h0
`define DMF_RST_RANGE_LOW 32'h00000000
`define DMF_RST_RANGE_HIGH 32'hFFFFFFFF
`define DMF_ST_FAULT_BIT 16
`define DMF_ST_SEEN_BIT 17
`define DMF_ST_JUMP_BIT 18

// ----------------------------------------
// axi responses
// ----------------------------------------
`define DMF_RESP_OKAY 2'h0
`define DMF_RESP_SLVERR 2'h2

// ----------------------------------------
// applicability mask bit positions
// ----------------------------------------
`define DMF_A_C10 0
`define DMF_A_C20 1
`define DMF_A_C100 2
`define DMF_A_G11 3
`define DMF_A_G12 4
`define DMF_A_G13 5
`define DMF_A_C190 6
`define DMF_A_C200 7
`define DMF_A_C300 8
`define DMF_A_C400 9

// ----------------------------------------
// fault codes
// ----------------------------------------
`define DMF_CODE_NONE 16'h0000
`define DMF_CODE_10 16'h000A
`define DMF_CODE_20 16'h0014
`define DMF_CODE_100 16'h0064
`define DMF_CODE_110 16'h006E
`define DMF_CODE_120 16'h0078
`define DMF_CODE_130 16'h0082
`define DMF_CODE_190 16'h00BE
`define DMF_CODE_200 16'h00C8
`define DMF_CODE_300 16'h012C
`define DMF_CODE_400 16'h0190

// ----------------------------------------
// timing
// ----------------------------------------
`define DMF_CLK_MHZ 200
`define DMF_PERSIST_MS 30

`endif

// ---- dmf_meter_model.sv ----
`timescale 1ns/100ps
module dmf_meter_model (
	input wire sys_clk,
	output reg headerOk,
	output reg dataOk,
	output reg frameImpermissible,
	output reg [31:0] distance,
	output reg meterError,
	output reg [1:0] meterErrorKind,
	output reg meterUnreliable
);
initial begin
	headerOk = 1'b0;
	dataOk = 1'b0;
	frameImpermissible = 1'b0;
	distance = 32'h00000000;
	meterError = 1'b0;
	meterErrorKind = 2'h0;
	meterUnreliable = 1'b0;
end
task frame(input [31:0] d, input bit hdrOnly);
	@(posedge sys_clk);
	headerOk <= 1'b1;
	@(posedge sys_clk);
	headerOk <= 1'b0;
	dataOk <= !hdrOnly;
	distance <= d;
	@(posedge sys_clk);
	dataOk <= 1'b0;
	// stale value never lingers
	distance <= ~d;
	repeat (2) @(posedge sys_clk);
endtask
task bad;
	@(posedge sys_clk);
	frameImpermissible <= 1'b1;
	@(posedge sys_clk);
	frameImpermissible <= 1'b0;
endtask
task err(input e, input [1:0] k, input u);
	@(posedge sys_clk);
	meterError <= e;
	meterErrorKind <= k;
	meterUnreliable <= u;
endtask
endmodule // dmf_meter_model

// ---- dmf_monitor.v ----
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "dmf_consts.vh"
module dmf_monitor #(
	parameter PERSIST_CYCLES = `DMF_PERSIST_MS * 1000 * `DMF_CLK_MHZ
) (
	input wire sys_clk,
	input wire arst_n,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire positionFeedPin,
	input wire driveRunningPin,
	input wire startCmdPin,
	input wire headerOk,
	input wire dataOk,
	input wire frameImpermissible,
	input wire [31:0] distance,
	input wire meterError,
	input wire [1:0] meterErrorKind,
	input wire meterUnreliable,
	output reg meterFault_r,
	output reg [15:0] faultCode_r,
	output reg [15:0] monitorCode_r
);
	// ----------------------------------------
	// functions
	// ----------------------------------------
	function [31:0] mergeBytes;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				mergeBytes[i*8 +: 8] = strb[i] ? data[i*8 +: 8] :
					old[i*8 +: 8];
			end
		end
	endfunction

	// which codes each meter type checks
	function [9:0] applicable;
		input [2:0] meterType;
		begin
			case (meterType)
				3'h0: applicable = 10'h185;
				3'h1: applicable = 10'h381;
				3'h2: applicable = 10'h189;
				3'h3: applicable = 10'h191;
				3'h4: applicable = 10'h1A1;
				3'h5: applicable = 10'h122;
				3'h6: applicable = 10'h140;
				default: applicable = 10'h340;
			endcase
		end
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] failMask_r;
	reg [2:0] meterType_r;
	reg [7:0] retryLimit_r;
	reg [31:0] commInterval_r;
	reg [31:0] measInterval_r;
	reg [3:0] linkSelect_r;
	reg runGating_r;
	reg [31:0] monSel_r;
	reg [7:0] monSelE_r;
	reg [31:0] rangeLow_r;
	reg [31:0] rangeHigh_r;
	reg [7:0] awAddr_r;
	reg awHave_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;
	reg wHave_r;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire posFeed;
	wire driveRunning;
	wire startCmd;

	dmf_sync3 syncFeed (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pinIn(positionFeedPin),
		.syncOut_r(posFeed)
	);
	dmf_sync3 syncRun (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pinIn(driveRunningPin),
		.syncOut_r(driveRunning)
	);
	dmf_sync3 syncStart (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pinIn(startCmdPin),
		.syncOut_r(startCmd)
	);

	// ----------------------------------------
	// detection gating
	// ----------------------------------------
	wire [9:0] appl = applicable(meterType_r);
	wire detectOn = failMask_r[`DMF_MASK_BIT] & posFeed
		& (linkSelect_r == `DMF_LINK_ACTIVE)
		& (~runGating_r | driveRunning);

	// ----------------------------------------
	// timeouts
	// ----------------------------------------
	reg [31:0] headerWait_r;
	reg [31:0] dataWait_r;
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			headerWait_r <= 32'h00000000;
			dataWait_r <= 32'h00000000;
		end else begin
			if (headerOk || !detectOn) begin
				headerWait_r <= 32'h00000000;
			end else if (headerWait_r < commInterval_r) begin
				headerWait_r <= headerWait_r + 32'h00000001;
			end
			if (dataOk || !detectOn) begin
				dataWait_r <= 32'h00000000;
			end else if (dataWait_r < measInterval_r) begin
				dataWait_r <= dataWait_r + 32'h00000001;
			end
		end
	end
	// not equality: an interval shortened below the count still trips
	wire hit10 = detectOn && !headerOk
		&& headerWait_r >= commInterval_r;
	wire hit20 = detectOn && !dataOk
		&& dataWait_r >= measInterval_r;

	// ----------------------------------------
	// persistence checks
	// ----------------------------------------
	reg zeroSeen_r;
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			zeroSeen_r <= 1'b0;
		end else if (dataOk) begin
			zeroSeen_r <= (distance == 32'h00000000);
		end
	end

	wire zeroHeld;
	wire errHeld;
	wire unrelHeld;
	dmf_persist #(.CNT_W(32), .HOLD_CYCLES(PERSIST_CYCLES)) persistZero (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.cond(zeroSeen_r),
		.held_r(zeroHeld)
	);
	dmf_persist #(.CNT_W(32), .HOLD_CYCLES(PERSIST_CYCLES)) persistErr (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.cond(meterError),
		.held_r(errHeld)
	);
	dmf_persist #(.CNT_W(32), .HOLD_CYCLES(PERSIST_CYCLES)) persistUnrel (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.cond(meterUnreliable),
		.held_r(unrelHeld)
	);

	wire [15:0] errKindExt = {14'h0000, meterErrorKind};
	wire kindOk12 = (meterErrorKind < 2'h2);
	wire kindOk13 = (meterErrorKind != 2'h3);

	// ----------------------------------------
	// impermissible frames, start, range jump
	// ----------------------------------------
	reg [8:0] impCount_r;
	reg everValid_r;
	reg startPrev_r;
	reg [1:0] region_r;
	reg jumpPend_r;
	wire below = (distance < rangeLow_r);
	wire above = (distance > rangeHigh_r);
	wire jumpNow = dataOk && ((region_r[0] && above)
		|| (region_r[1] && below));

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			impCount_r <= 9'h000;
			everValid_r <= 1'b0;
			startPrev_r <= 1'b0;
			region_r <= 2'h0;
			jumpPend_r <= 1'b0;
		end else begin
			if (dataOk) begin
				impCount_r <= 9'h000;
			end else if (frameImpermissible && impCount_r != 9'h1FF) begin
				impCount_r <= impCount_r + 9'h001;
			end
			if (dataOk) begin
				everValid_r <= 1'b1;
				region_r <= {above, below};
			end
			startPrev_r <= startCmd;
			if (jumpNow) begin
				jumpPend_r <= 1'b1;
			end
		end
	end

	wire hit200 = detectOn
		&& impCount_r > {1'b0, retryLimit_r};
	wire hit300 = detectOn && startCmd && !startPrev_r
		&& !everValid_r;
	wire hit400 = detectOn && (jumpPend_r || jumpNow);

	// ----------------------------------------
	// fault latch, first code wins
	// ----------------------------------------
	reg [15:0] codeNxt;
	always @* begin
		codeNxt = `DMF_CODE_NONE;
		if (appl[`DMF_A_C10] && hit10) begin
			codeNxt = `DMF_CODE_10;
		end else if (appl[`DMF_A_C20] && hit20) begin
			codeNxt = `DMF_CODE_20;
		end else if (appl[`DMF_A_C100] && detectOn && zeroHeld) begin
			codeNxt = `DMF_CODE_100;
		end else if (appl[`DMF_A_G11] && detectOn && errHeld
				&& kindOk12) begin
			codeNxt = `DMF_CODE_110 + errKindExt;
		end else if (appl[`DMF_A_G12] && detectOn && errHeld
				&& kindOk12) begin
			codeNxt = `DMF_CODE_120 + errKindExt;
		end else if (appl[`DMF_A_G13] && detectOn && errHeld
				&& kindOk13) begin
			codeNxt = `DMF_CODE_130 + errKindExt;
		end else if (appl[`DMF_A_C190] && detectOn && unrelHeld) begin
			codeNxt = `DMF_CODE_190;
		end else if (appl[`DMF_A_C200] && hit200) begin
			codeNxt = `DMF_CODE_200;
		end else if (appl[`DMF_A_C300] && hit300) begin
			codeNxt = `DMF_CODE_300;
		end else if (appl[`DMF_A_C400] && hit400) begin
			codeNxt = `DMF_CODE_400;
		end
	end

	wire showCode = (monSel_r[7:0] == `DMF_MON_SHOW_CODE)
		|| (monSel_r[15:8] == `DMF_MON_SHOW_CODE)
		|| (monSel_r[23:16] == `DMF_MON_SHOW_CODE)
		|| (monSel_r[31:24] == `DMF_MON_SHOW_CODE)
		|| (monSelE_r == `DMF_MON_SHOW_CODE);

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meterFault_r <= 1'b0;
			faultCode_r <= `DMF_CODE_NONE;
			monitorCode_r <= `DMF_CODE_NONE;
		end else begin
			if (!meterFault_r && codeNxt != `DMF_CODE_NONE) begin
				meterFault_r <= 1'b1;
				faultCode_r <= codeNxt;
			end
			monitorCode_r <= showCode ? faultCode_r :
				`DMF_CODE_NONE;
		end
	end

	// ----------------------------------------
	// axi4-lite write path
	// ----------------------------------------
	wire doWrite = awHave_r && wHave_r && !s_axi_bvalid;
	wire [31:0] wrVal = mergeBytes(32'h00000000, wData_r, wStrb_r);
	wire [31:0] wrMask = mergeBytes(32'h00000000, 32'hFFFFFFFF, wStrb_r);

	function [31:0] applyWrite;
		input [31:0] old;
		input [31:0] val;
		input [31:0] mask;
		begin
			applyWrite = (old & ~mask) | (val & mask);
		end
	endfunction

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DMF_RESP_OKAY;
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			failMask_r <= `DMF_RST_FAIL_MASK;
			meterType_r <= `DMF_RST_METER_TYPE;
			retryLimit_r <= `DMF_RST_RETRY_LIMIT;
			commInterval_r <= `DMF_RST_INTERVAL;
			measInterval_r <= `DMF_RST_INTERVAL;
			linkSelect_r <= `DMF_RST_LINK_SELECT;
			runGating_r <= 1'b0;
			monSel_r <= 32'h00000000;
			monSelE_r <= 8'h00;
			rangeLow_r <= `DMF_RST_RANGE_LOW;
			rangeHigh_r <= `DMF_RST_RANGE_HIGH;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_r <= s_axi_awaddr;
				awHave_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				wHave_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `DMF_RESP_OKAY;
				if (awAddr_r == `DMF_OFS_FAIL_MASK) begin
					failMask_r <= wrMask[0] ? wData_r[7:0] : failMask_r;
				end else if (awAddr_r == `DMF_OFS_METER_TYPE) begin
					meterType_r <= wrMask[0] ? wData_r[2:0] : meterType_r;
				end else if (awAddr_r == `DMF_OFS_RETRY_LIMIT) begin
					retryLimit_r <= wrMask[0] ? wData_r[7:0] : retryLimit_r;
				end else if (awAddr_r == `DMF_OFS_COMM_INTERVAL) begin
					commInterval_r <= applyWrite(commInterval_r, wrVal, wrMask);
				end else if (awAddr_r == `DMF_OFS_MEAS_INTERVAL) begin
					measInterval_r <= applyWrite(measInterval_r, wrVal, wrMask);
				end else if (awAddr_r == `DMF_OFS_LINK_SELECT) begin
					linkSelect_r <= wrMask[0] ? wData_r[3:0] : linkSelect_r;
				end else if (awAddr_r == `DMF_OFS_RUN_GATING) begin
					runGating_r <= wrMask[0] ? wData_r[0] : runGating_r;
				end else if (awAddr_r == `DMF_OFS_MON_SEL) begin
					monSel_r <= applyWrite(monSel_r, wrVal, wrMask);
				end else if (awAddr_r == `DMF_OFS_MON_SEL_E) begin
					monSelE_r <= wrMask[0] ? wData_r[7:0] : monSelE_r;
				end else if (awAddr_r == `DMF_OFS_RANGE_LOW) begin
					rangeLow_r <= applyWrite(rangeLow_r, wrVal, wrMask);
				end else if (awAddr_r == `DMF_OFS_RANGE_HIGH) begin
					rangeHigh_r <= applyWrite(rangeHigh_r, wrVal, wrMask);
				end else if (awAddr_r != `DMF_OFS_STATUS) begin
					s_axi_bresp <= `DMF_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read path
	// ----------------------------------------
	reg [31:0] rdVal;
	reg rdHit;
	always @* begin
		rdVal = 32'h00000000;
		rdHit = 1'b1;
		if (s_axi_araddr == `DMF_OFS_FAIL_MASK) begin
			rdVal = {24'h000000, failMask_r};
		end else if (s_axi_araddr == `DMF_OFS_METER_TYPE) begin
			rdVal = {29'h00000000, meterType_r};
		end else if (s_axi_araddr == `DMF_OFS_RETRY_LIMIT) begin
			rdVal = {24'h000000, retryLimit_r};
		end else if (s_axi_araddr == `DMF_OFS_COMM_INTERVAL) begin
			rdVal = commInterval_r;
		end else if (s_axi_araddr == `DMF_OFS_MEAS_INTERVAL) begin
			rdVal = measInterval_r;
		end else if (s_axi_araddr == `DMF_OFS_LINK_SELECT) begin
			rdVal = {28'h0000000, linkSelect_r};
		end else if (s_axi_araddr == `DMF_OFS_RUN_GATING) begin
			rdVal = {31'h00000000, runGating_r};
		end else if (s_axi_araddr == `DMF_OFS_MON_SEL) begin
			rdVal = monSel_r;
		end else if (s_axi_araddr == `DMF_OFS_MON_SEL_E) begin
			rdVal = {24'h000000, monSelE_r};
		end else if (s_axi_araddr == `DMF_OFS_STATUS) begin
			rdVal = {16'h0000, faultCode_r};
			rdVal[`DMF_ST_FAULT_BIT] = meterFault_r;
			rdVal[`DMF_ST_SEEN_BIT] = everValid_r;
			rdVal[`DMF_ST_JUMP_BIT] = jumpPend_r;
		end else if (s_axi_araddr == `DMF_OFS_RANGE_LOW) begin
			rdVal = rangeLow_r;
		end else if (s_axi_araddr == `DMF_OFS_RANGE_HIGH) begin
			rdVal = rangeHigh_r;
		end else begin
			rdHit = 1'b0;
		end
	end

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `DMF_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdVal;
				s_axi_rresp <= rdHit ? `DMF_RESP_OKAY : `DMF_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // dmf_monitor

// ---- dmf_monitor_assertions.sv ----
`timescale 1ns/100ps
`include "dmf_consts.vh"
module dmf_monitor_chk #(
	parameter int PERSIST_CYCLES = 6000000
) (
	input wire sys_clk,
	input wire arst_n,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire dataOk,
	input wire frameImpermissible,
	input wire [31:0] distance,
	input wire meterFault_r,
	input wire [15:0] faultCode_r,
	input wire [15:0] monitorCode_r
);
reg seenData_r;
reg lastZero_r;
reg [31:0] zeroRun_r;
reg [9:0] badRun_r;
// ----------------------------------------
// frame history seen at the ports
// ----------------------------------------
always @(posedge sys_clk or negedge arst_n) begin
	if (!arst_n) begin
		seenData_r <= 1'b0;
		lastZero_r <= 1'b0;
		zeroRun_r <= 32'h00000000;
		badRun_r <= 10'h000;
	end else begin
		if (dataOk)
			seenData_r <= 1'b1;
		if (dataOk)
			lastZero_r <= (distance == 32'h00000000);
		if (dataOk && distance != 32'h00000000)
			zeroRun_r <= 32'h00000000;
		else if (lastZero_r && zeroRun_r != 32'hFFFFFFFF)
			zeroRun_r <= zeroRun_r + 32'h00000001;
		if (dataOk)
			badRun_r <= 10'h000;
		else if (frameImpermissible && badRun_r != 10'h3FF)
			badRun_r <= badRun_r + 10'h001;
	end
end
default clocking cb @(posedge sys_clk);
endclocking
default disable iff (!arst_n);
a_fault_held: assert property (meterFault_r |=> meterFault_r)
	else $error("fault flag dropped");
a_code_held: assert property (meterFault_r |=> $stable(faultCode_r))
	else $error("stored code changed");
a_flag_code: assert property (meterFault_r == (faultCode_r != 16'h0000))
	else $error("flag and code disagree");
a_code_known: assert property ($rose(meterFault_r) |-> faultCode_r inside {
	`DMF_CODE_10, `DMF_CODE_20, `DMF_CODE_100, [`DMF_CODE_110:16'h006F],
	[`DMF_CODE_120:16'h0079], [`DMF_CODE_130:16'h0084], `DMF_CODE_190,
	`DMF_CODE_200, `DMF_CODE_300, `DMF_CODE_400})
	else $error("unknown fault code");
a_monitor_src: assert property (monitorCode_r != 16'h0000 |->
	monitorCode_r == $past(faultCode_r)) else $error("monitor code wrong");
a_start_nodata: assert property ($rose(meterFault_r) &&
	faultCode_r == `DMF_CODE_300 |-> !$past(seenData_r))
	else $error("start fault after data");
a_jump_data: assert property ($rose(meterFault_r) &&
	faultCode_r == `DMF_CODE_400 |-> seenData_r)
	else $error("jump fault without data");
a_zero_time: assert property ($rose(meterFault_r) &&
	faultCode_r == `DMF_CODE_100 |->
	$past(lastZero_r, 2) && $past(zeroRun_r, 2) >= PERSIST_CYCLES - 1)
	else $error("zero fault too early");
a_bad_count: assert property ($rose(meterFault_r) &&
	faultCode_r == `DMF_CODE_200 |-> $past(badRun_r) != 10'h000)
	else $error("retry fault without bad frames");
a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
	s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
	else $error("write answer late");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
	s_axi_rvalid) else $error("read answer late");
endmodule // dmf_monitor_chk

bind dmf_monitor dmf_monitor_chk #(.PERSIST_CYCLES(PERSIST_CYCLES)) chk (
	.sys_clk(sys_clk),
	.arst_n(arst_n),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.dataOk(dataOk),
	.frameImpermissible(frameImpermissible),
	.distance(distance),
	.meterFault_r(meterFault_r),
	.faultCode_r(faultCode_r),
	.monitorCode_r(monitorCode_r)
);

// ---- dmf_monitor_test.sv ----
`timescale 1ns/100ps
`include "dmf_consts.vh"
module dmf_monitor_test;
localparam int PERSIST = 20;
localparam [1:0] OK = `DMF_RESP_OKAY;
localparam [1:0] ERR = `DMF_RESP_SLVERR;
reg sys_clk;
reg arst_n = 1'b0;
reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
reg [31:0] s_axi_wdata = 32'h00000000;
reg positionFeedPin = 1'b1, driveRunningPin = 1'b0, startCmdPin = 1'b0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp, meterErrorKind;
wire [31:0] s_axi_rdata, distance;
wire headerOk, dataOk, frameImpermissible, meterError, meterUnreliable;
wire meterFault_r;
wire [15:0] faultCode_r, monitorCode_r;
int nFail = 0, cmpCount = 0, t, k, f;
initial begin
	sys_clk = 1'b0;
	forever #2.5 sys_clk = ~sys_clk;
end
dmf_monitor #(.PERSIST_CYCLES(PERSIST)) DUT (
	.sys_clk(sys_clk), .arst_n(arst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .positionFeedPin(positionFeedPin),
	.driveRunningPin(driveRunningPin), .startCmdPin(startCmdPin),
	.headerOk(headerOk), .dataOk(dataOk),
	.frameImpermissible(frameImpermissible), .distance(distance),
	.meterError(meterError), .meterErrorKind(meterErrorKind),
	.meterUnreliable(meterUnreliable), .meterFault_r(meterFault_r),
	.faultCode_r(faultCode_r), .monitorCode_r(monitorCode_r)
);
dmf_meter_model meter (
	.sys_clk(sys_clk), .headerOk(headerOk), .dataOk(dataOk),
	.frameImpermissible(frameImpermissible), .distance(distance),
	.meterError(meterError), .meterErrorKind(meterErrorKind),
	.meterUnreliable(meterUnreliable)
);
task cmp(input logic [31:0] g, input logic [31:0] e);
	cmpCount++;
	if (g !== e) begin
		nFail++;
		$display("mismatch at %0t: got %h want %h", $time, g, e);
	end
endtask
task report_and_stop;
	$display("comparisons %0d mismatches %0d", cmpCount, nFail);
	if (nFail == 0 && cmpCount > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
task tick(input int n);
	repeat (n) @(posedge sys_clk);
endtask
task wr(input [7:0] a, input [31:0] d, input [1:0] r);
	bit aw, w;
	@(posedge sys_clk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	aw = 1'b0;
	w = 1'b0;
	while (!(aw && w)) begin
		@(posedge sys_clk);
		if (s_axi_awready === 1'b1)
			s_axi_awvalid <= 1'b0;
		if (s_axi_wready === 1'b1)
			s_axi_wvalid <= 1'b0;
		aw = aw | (s_axi_awready === 1'b1);
		w = w | (s_axi_wready === 1'b1);
	end
	do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
	s_axi_bready <= 1'b0;
	cmp({30'h0, s_axi_bresp}, {30'h0, r});
endtask
task rd(input [7:0] a, input [31:0] e, input [1:0] r);
	@(posedge sys_clk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
	s_axi_arvalid <= 1'b0;
	do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
	s_axi_rready <= 1'b0;
	cmp(s_axi_rdata, e);
	cmp({30'h0, s_axi_rresp}, {30'h0, r});
endtask
task chkCode(input [15:0] c);
	cmp({15'h0, meterFault_r, faultCode_r}, {15'h0, c != 16'h0, c});
endtask
task start(input [7:0] m, input [2:0] ty);
	@(posedge sys_clk);
	arst_n <= 1'b0;
	tick(10);
	arst_n <= 1'b1;
	wr(`DMF_OFS_FAIL_MASK, {24'h0, m}, OK);
	wr(`DMF_OFS_METER_TYPE, {29'h0, ty}, OK);
	wr(`DMF_OFS_LINK_SELECT, 32'h1, OK);
	tick(5);
endtask
initial begin
	start(8'hEF, 3'h0);
	rd(`DMF_OFS_RETRY_LIMIT, 32'h3, OK);
	rd(`DMF_OFS_COMM_INTERVAL, `DMF_RST_INTERVAL, OK);
	rd(`DMF_OFS_RANGE_HIGH, `DMF_RST_RANGE_HIGH, OK);
	rd(8'h30, 32'h0, ERR);
	wr(8'h40, 32'h1, ERR);
	repeat (5) meter.bad();
	startCmdPin <= 1'b1;
	tick(10);
	chkCode(16'h0);
	startCmdPin <= 1'b0;
	start(8'h10, 3'h0);
	meter.frame(32'h40, 0);
	startCmdPin <= 1'b1;
	repeat (3) meter.bad();
	meter.frame(32'h40, 0);
	repeat (3) meter.bad();
	tick(5);
	chkCode(16'h0);
	meter.bad();
	tick(5);
	chkCode(`DMF_CODE_200);
	meter.frame(32'h0, 0);
	tick(40);
	chkCode(`DMF_CODE_200);
	startCmdPin <= 1'b0;
	start(8'h10, 3'h0);
	startCmdPin <= 1'b1;
	tick(10);
	chkCode(`DMF_CODE_300);
	startCmdPin <= 1'b0;
	start(8'h10, 3'h0);
	meter.frame(32'h0, 0);
	tick(10);
	chkCode(16'h0);
	tick(15);
	chkCode(`DMF_CODE_100);
	for (t = 2; t < 5; t++)
		for (k = 0; k < (t == 4 ? 3 : 2); k++) begin
			start(8'h10, t[2:0]);
			meter.err(1'b1, k[1:0], 1'b0);
			tick(12);
			chkCode(16'h0);
			tick(20);
			chkCode(16'(`DMF_CODE_110 + 10 * (t - 2) + k));
			meter.err(1'b0, 2'h0, 1'b0);
		end
	start(8'h10, 3'h6);
	repeat (5) meter.bad();
	tick(3);
	chkCode(16'h0);
	meter.err(1'b0, 2'h0, 1'b1);
	tick(32);
	chkCode(`DMF_CODE_190);
	meter.err(1'b0, 2'h0, 1'b0);
	wr(`DMF_OFS_MON_SEL, {16'h0, `DMF_MON_SHOW_CODE, 8'h0}, OK);
	tick(3);
	cmp({16'h0, monitorCode_r}, {16'h0, `DMF_CODE_190});
	wr(`DMF_OFS_MON_SEL, 32'h0, OK);
	wr(`DMF_OFS_MON_SEL_E, {24'h0, `DMF_MON_SHOW_CODE}, OK);
	tick(3);
	cmp({16'h0, monitorCode_r}, {16'h0, `DMF_CODE_190});
	wr(`DMF_OFS_MON_SEL_E, 32'h35, OK);
	tick(3);
	cmp({16'h0, monitorCode_r}, 32'h0);
	rd(`DMF_OFS_STATUS, {15'h0, 1'b1, `DMF_CODE_190}, OK);
	start(8'h10, 3'h5);
	wr(`DMF_OFS_MEAS_INTERVAL, 32'h28, OK);
	repeat (12) meter.frame(32'h40, 1);
	chkCode(`DMF_CODE_20);
	start(8'h10, 3'h0);
	wr(`DMF_OFS_RUN_GATING, 32'h1, OK);
	wr(`DMF_OFS_COMM_INTERVAL, 32'h28, OK);
	tick(80);
	chkCode(16'h0);
	driveRunningPin <= 1'b1;
	tick(50);
	chkCode(`DMF_CODE_10);
	driveRunningPin <= 1'b0;
	for (f = 0; f < 2; f++) begin
		start(8'h10, f == 0 ? 3'h1 : 3'h7);
		wr(`DMF_OFS_RANGE_LOW, 32'h64, OK);
		wr(`DMF_OFS_RANGE_HIGH, 32'hC8, OK);
		positionFeedPin <= (f == 0);
		tick(6);
		meter.frame(32'h32, 0);
		meter.frame(32'h12C, 0);
		tick(10);
		chkCode(f == 0 ? `DMF_CODE_400 : 16'h0);
		positionFeedPin <= 1'b1;
		tick(8);
		chkCode(`DMF_CODE_400);
	end
	report_and_stop;
end
initial begin
	tick(20000);
	nFail++;
	$display("mismatch at %0t: watchdog expired", $time);
	report_and_stop;
end
endmodule // dmf_monitor_test

// ---- dmf_persist.v ----
`timescale 1ns/100ps
module dmf_persist #(
	parameter CNT_W = 24,
	parameter [CNT_W-1:0] HOLD_CYCLES = 6000000
) (
	input wire sys_clk,
	input wire arst_n,
	input wire cond,
	output reg held_r
);
	reg [CNT_W-1:0] cnt_r;

	// any gap in cond restarts the count
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= {CNT_W{1'b0}};
			held_r <= 1'b0;
		end else if (!cond) begin
			cnt_r <= {CNT_W{1'b0}};
			held_r <= 1'b0;
		end else begin
			if (cnt_r != HOLD_CYCLES) begin
				cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
			end
			held_r <= (cnt_r == HOLD_CYCLES - {{(CNT_W-1){1'b0}}, 1'b1})
				| held_r;
		end
	end
endmodule // dmf_persist

// ---- dmf_sync3.v ----
`timescale 1ns/100ps
module dmf_sync3 (
	input wire sys_clk,
	input wire arst_n,
	input wire pinIn,
	output reg syncOut_r
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	// change accepted once stages two and three agree
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			syncOut_r <= 1'b0;
		end else begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				syncOut_r <= s3_r;
			end
		end
	end
endmodule // dmf_sync3
